// File: verilog/crnc_framer.sv
// Completer request framer: forwards request beats to the user, diverts
// non-posted packets into a holding queue while credit is zero or others wait.
// Assumes the upstream request source and the user run on CLOCK_IN.
// The credit level output follows the internal counter with no added lag.
`timescale 1ns/1ps
module crnc_framer #(
    parameter int Q_DEPTH = crnc_pkg::NP_Q_DEPTH
) (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic LINK_VALID_IN,
    output logic LINK_READY_OUT,
    input wire logic [crnc_pkg::DATA_W-1:0] LINK_DATA_IN,
    input wire logic [crnc_pkg::KEEP_W-1:0] LINK_KEEP_IN,
    input wire logic LINK_LAST_IN,
    input wire logic LINK_SOP_IN,
    input wire logic LINK_NP_IN,
    input crnc_pkg::crnc_kind_t LINK_KIND_IN,
    input wire logic [3:0] LINK_FIRST_BE_IN,
    input wire logic [3:0] LINK_LAST_BE_IN,
    input wire logic [crnc_pkg::BE_W-1:0] LINK_BYTE_EN_IN,
    input wire logic LINK_ECC_ERR_IN,
    output logic REQ_VALID_OUT,
    input wire logic REQ_READY_IN,
    output logic [crnc_pkg::DATA_W-1:0] REQ_DATA_OUT,
    output logic [crnc_pkg::KEEP_W-1:0] REQ_BYTE_KEEP_OUT,
    output logic REQ_LAST_BEAT_OUT,
    output logic [crnc_pkg::SB_W-1:0] REQ_SIDEBAND_BUS_OUT,
    input wire logic NONPOSTED_CREDIT_GRANT_IN,
    output logic [crnc_pkg::CREDIT_W-1:0] NONPOSTED_CREDIT_LEVEL_OUT,
    output logic FATAL_ERROR_OUT
);
    import crnc_pkg::*;

    localparam int PTR_W = $clog2(Q_DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] Q_FULL = CNT_W'(Q_DEPTH);

    // Capture stage, output stage and source tracking.
    crnc_beat_t hold, next_hold, cap_beat;
    logic hold_valid, next_hold_valid;
    logic link_ready, next_link_ready;
    logic pkt_err, next_pkt_err;
    crnc_beat_t out_beat, next_out_beat;
    logic out_valid, next_out_valid;
    crnc_src_t src, next_src;
    logic divert_pkt, next_divert_pkt;
    logic fatal, next_fatal;
    logic [CREDIT_W-1:0] credit, next_credit;

    // Non-posted holding queue.
    crnc_beat_t q_mem [Q_DEPTH];
    crnc_beat_t q_head;
    logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [CNT_W-1:0] q_count, next_q_count;

    logic accept, slot_free, divert_cond, divert, take_queue, take_hold, np_start;

    function automatic logic be_unused(input crnc_kind_t kind);
        be_unused = (kind == KIND_ATOMIC) || (kind == KIND_MSG);
    endfunction : be_unused

    always_comb begin
        accept = LINK_VALID_IN && link_ready;
        slot_free = !out_valid || REQ_READY_IN;
        q_head = q_mem[rd_ptr];
        cap_beat.data = LINK_DATA_IN;
        cap_beat.keep = LINK_KEEP_IN;
        cap_beat.last = LINK_LAST_IN;
        cap_beat.sop = LINK_SOP_IN;
        cap_beat.np = LINK_NP_IN;
        cap_beat.kind = LINK_KIND_IN;
        // First and last byte enables of the start beat only; atomics and messages carry none.
        cap_beat.first_be = (LINK_SOP_IN && !be_unused(LINK_KIND_IN)) ? LINK_FIRST_BE_IN : BE_NONE;
        cap_beat.last_be = (LINK_SOP_IN && !be_unused(LINK_KIND_IN)) ? LINK_LAST_BE_IN : BE_NONE;
        cap_beat.byte_en = LINK_BYTE_EN_IN;
        // A storage error anywhere in the packet aborts it on its last beat.
        cap_beat.disc = LINK_LAST_IN && (pkt_err || LINK_ECC_ERR_IN);

        // A non-posted start goes to the queue when credit is out or others wait.
        divert_cond = hold_valid && (divert_pkt || (hold.sop && hold.np && src != SRC_LINK
            && (credit == CREDIT_RESET || q_count != '0 || src == SRC_QUEUE)));
        divert = divert_cond && (q_count != Q_FULL);
        take_queue = 1'b0;
        take_hold = 1'b0;
        // Pick the source of the next output beat; the queue wins once credit exists.
        case (src)
            SRC_IDLE: begin
                if (slot_free && q_count != '0 && credit != CREDIT_RESET) begin
                    take_queue = 1'b1;
                end else if (slot_free && hold_valid && hold.sop && !divert_cond) begin
                    take_hold = 1'b1;
                end
            end
            SRC_LINK: take_hold = slot_free && hold_valid && !divert_cond;
            SRC_QUEUE: take_queue = slot_free && q_count != '0;
            default: take_hold = 1'b0;
        endcase
        np_start = (take_queue && q_head.sop) || (take_hold && hold.sop && hold.np);

        next_src = src;
        if (take_queue) begin
            next_src = q_head.last ? SRC_IDLE : SRC_QUEUE;
        end else if (take_hold) begin
            next_src = hold.last ? SRC_IDLE : SRC_LINK;
        end
        next_out_valid = out_valid;
        next_out_beat = out_beat;
        if (slot_free) begin
            next_out_valid = take_queue || take_hold;
            next_out_beat = take_queue ? q_head : hold;
        end
        next_divert_pkt = divert ? !hold.last : divert_pkt;
        next_hold_valid = (hold_valid && !(take_hold || divert)) || accept;
        next_hold = accept ? cap_beat : hold;
        next_link_ready = !next_hold_valid;
        // The error flag spans the packet so a fault on any beat reaches its last beat.
        next_pkt_err = pkt_err;
        if (accept) begin
            next_pkt_err = !LINK_LAST_IN && (pkt_err || LINK_ECC_ERR_IN);
        end
        next_fatal = fatal || ((take_queue || take_hold) && next_out_beat.disc);

        // A start is a non-posted first beat loaded into the output register,
        // not the user's take, so the gate and the level never disagree.
        next_credit = credit;
        if (NONPOSTED_CREDIT_GRANT_IN && !np_start && credit != CREDIT_MAX) begin
            next_credit = credit + CREDIT_ONE;
        end else if (!NONPOSTED_CREDIT_GRANT_IN && np_start && credit != CREDIT_RESET) begin
            next_credit = credit - CREDIT_ONE;
        end

        // Pointers wrap freely; q_count alone tells full from empty.
        next_wr_ptr = divert ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = take_queue ? rd_ptr + 1'b1 : rd_ptr;
        next_q_count = q_count + CNT_W'(divert) - CNT_W'(take_queue);
    end

    // Every register below is cleared by the synchronous reset.
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            hold <= '0;
            hold_valid <= 1'b0;
            link_ready <= 1'b0;
            pkt_err <= 1'b0;
            out_beat <= '0;
            out_valid <= 1'b0;
            src <= SRC_IDLE;
            divert_pkt <= 1'b0;
            fatal <= 1'b0;
            credit <= CREDIT_RESET;
            wr_ptr <= '0;
            rd_ptr <= '0;
            q_count <= '0;
        end else begin
            hold <= next_hold;
            hold_valid <= next_hold_valid;
            link_ready <= next_link_ready;
            pkt_err <= next_pkt_err;
            out_beat <= next_out_beat;
            out_valid <= next_out_valid;
            src <= next_src;
            divert_pkt <= next_divert_pkt;
            fatal <= next_fatal;
            credit <= next_credit;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            q_count <= next_q_count;
        end
    end

    // The queue storage has no reset; q_count guards every read of it.
    always_ff @(posedge CLOCK_IN) begin
        if (divert) begin
            q_mem[wr_ptr] <= hold;
        end
    end

    // All outputs come straight from registers; the sideband packs flags over the enables.
    assign LINK_READY_OUT = link_ready;
    assign REQ_VALID_OUT = out_valid;
    assign REQ_DATA_OUT = out_beat.data;
    assign REQ_BYTE_KEEP_OUT = out_beat.keep;
    assign REQ_LAST_BEAT_OUT = out_beat.last;
    assign REQ_SIDEBAND_BUS_OUT = {out_beat.disc, out_beat.sop, out_beat.byte_en,
        out_beat.last_be, out_beat.first_be};
    assign NONPOSTED_CREDIT_LEVEL_OUT = credit;
    assign FATAL_ERROR_OUT = fatal;

    // All checks run on the one clock; all but credit_reset_a sleep while reset is held.
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    credit_reset_a: assert property (disable iff (1'b0) !RST_N_IN |=>
        NONPOSTED_CREDIT_LEVEL_OUT == CREDIT_RESET) else $error("credit not zero after reset");
    credit_up_a: assert property (NONPOSTED_CREDIT_GRANT_IN && !np_start
        && NONPOSTED_CREDIT_LEVEL_OUT != CREDIT_MAX
        |=> NONPOSTED_CREDIT_LEVEL_OUT == $past(NONPOSTED_CREDIT_LEVEL_OUT) + CREDIT_ONE)
        else $error("credit did not increment");
    credit_down_a: assert property (!NONPOSTED_CREDIT_GRANT_IN && np_start
        |=> NONPOSTED_CREDIT_LEVEL_OUT == $past(NONPOSTED_CREDIT_LEVEL_OUT) - CREDIT_ONE)
        else $error("credit did not decrement");
    credit_still_a: assert property (NONPOSTED_CREDIT_GRANT_IN == np_start
        |=> $stable(NONPOSTED_CREDIT_LEVEL_OUT)) else $error("credit moved unexpectedly");
    credit_cap_a: assert property (NONPOSTED_CREDIT_LEVEL_OUT <= CREDIT_MAX)
        else $error("credit above saturation");
    np_gate_a: assert property (np_start |-> NONPOSTED_CREDIT_LEVEL_OUT != CREDIT_RESET
        ##1 REQ_VALID_OUT && REQ_SIDEBAND_BUS_OUT[SB_SOP_BIT] && out_beat.np)
        else $error("non-posted start without credit");
    be_sop_a: assert property (REQ_VALID_OUT && !REQ_SIDEBAND_BUS_OUT[SB_SOP_BIT]
        |-> REQ_SIDEBAND_BUS_OUT[SB_BYTE_EN_LSB-1:0] == '0) else $error("enables off start beat");
    atomic_be_a: assert property (REQ_VALID_OUT && out_beat.kind == KIND_ATOMIC
        |-> out_beat.first_be == BE_NONE && out_beat.last_be == BE_NONE)
        else $error("atomic carries first or last enables");
    msg_be_a: assert property (REQ_VALID_OUT && out_beat.kind == KIND_MSG
        |-> out_beat.first_be == BE_NONE && out_beat.last_be == BE_NONE)
        else $error("message carries first or last enables");
    abort_last_a: assert property (REQ_VALID_OUT && REQ_SIDEBAND_BUS_OUT[SB_DISCONTINUE_BIT]
        |-> REQ_LAST_BEAT_OUT ##1 FATAL_ERROR_OUT) else $error("abort off last beat");
    posted_pass_a: assert property (src == SRC_IDLE && slot_free && hold_valid && hold.sop
        && !hold.np && !(q_count != '0 && credit != CREDIT_RESET)
        |=> REQ_VALID_OUT && REQ_SIDEBAND_BUS_OUT[SB_SOP_BIT] && !out_beat.np)
        else $error("posted request blocked");
    queue_first_a: assert property (src == SRC_IDLE && slot_free && q_count != '0
        && credit != CREDIT_RESET |=> REQ_VALID_OUT && out_beat.np && src != SRC_LINK)
        else $error("queued request not drained first");
    stall_hold_a: assert property (REQ_VALID_OUT && !REQ_READY_IN
        |=> REQ_VALID_OUT && $stable(REQ_DATA_OUT) && $stable(REQ_SIDEBAND_BUS_OUT))
        else $error("beat changed while stalled");

    // The counter must neither wrap past saturation nor underflow at zero.
    sat_hold_a: assert property (NONPOSTED_CREDIT_GRANT_IN
        && NONPOSTED_CREDIT_LEVEL_OUT == CREDIT_MAX
        |=> NONPOSTED_CREDIT_LEVEL_OUT == CREDIT_MAX)
        else $error("credit wrapped past saturation");
    floor_hold_a: assert property (!NONPOSTED_CREDIT_GRANT_IN
        && NONPOSTED_CREDIT_LEVEL_OUT == CREDIT_RESET
        |=> NONPOSTED_CREDIT_LEVEL_OUT == CREDIT_RESET)
        else $error("credit wrapped below zero");

    // With no credit a waiting non-posted first beat must not reach the output.
    np_block_a: assert property (credit == CREDIT_RESET && src == SRC_IDLE
        && slot_free && hold_valid && hold.sop && hold.np
        |=> !REQ_VALID_OUT)
        else $error("non-posted beat passed without credit");

    // Abort may only ride on a last beat, and the fatal flag never clears itself.
    disc_last_a: assert property (REQ_VALID_OUT && !REQ_LAST_BEAT_OUT
        |-> !REQ_SIDEBAND_BUS_OUT[SB_DISCONTINUE_BIT])
        else $error("abort on a middle beat");
    fatal_sticky_a: assert property (FATAL_ERROR_OUT |=> FATAL_ERROR_OUT)
        else $error("fatal flag cleared without reset");

    // The capture stage holds one beat, so ready drops right after each take.
    link_take_a: assert property (LINK_VALID_IN && LINK_READY_OUT
        |=> !LINK_READY_OUT)
        else $error("upstream ready stayed high after a take");
    queue_bound_a: assert property (q_count <= Q_FULL)
        else $error("queue count past its depth");

    // A packet already passing from the link keeps flowing whatever the credit.
    posted_flow_a: assert property (src == SRC_LINK && slot_free && hold_valid
        |=> REQ_VALID_OUT)
        else $error("packet in flight was stalled");

    // A queued packet being drained keeps the output until its last beat.
    queue_drain_a: assert property (src == SRC_QUEUE && slot_free && q_count != '0
        |=> REQ_VALID_OUT && out_beat.np)
        else $error("queued packet interrupted");

    divert_c: cover property (divert && credit == CREDIT_RESET ##[1:50] take_queue);
    saturate_c: cover property (NONPOSTED_CREDIT_LEVEL_OUT == CREDIT_MAX);
    abort_c: cover property (REQ_VALID_OUT && REQ_SIDEBAND_BUS_OUT[SB_DISCONTINUE_BIT]);
    bypass_c: cover property (q_count != '0 && take_hold && hold.sop && !hold.np);
    posted_stall_c: cover property (q_count != '0 && credit == CREDIT_RESET && take_hold);
endmodule : crnc_framer

// File: common/crnc_pkg.sv
// Package for the completer request framer with non-posted credit control.
// Assumes a 128-bit request path and one user clock shared by all logic.
package crnc_pkg;
    localparam int DATA_W = 128;
    localparam int KEEP_W = DATA_W / 32;
    localparam int BE_W = DATA_W / 8;
    localparam int NP_Q_DEPTH = 64;
    localparam int CREDIT_W = 6;
    localparam logic [CREDIT_W-1:0] CREDIT_RESET = 6'h00;
    localparam logic [CREDIT_W-1:0] CREDIT_MAX = 6'h20;
    localparam logic [CREDIT_W-1:0] CREDIT_ONE = 6'h01;
    localparam logic [3:0] BE_NONE = 4'h0;
    localparam int SB_FIRST_BE_LSB = 0;
    localparam int SB_LAST_BE_LSB = 4;
    localparam int SB_BYTE_EN_LSB = 8;
    localparam int SB_SOP_BIT = SB_BYTE_EN_LSB + BE_W;
    localparam int SB_DISCONTINUE_BIT = SB_SOP_BIT + 1;
    localparam int SB_W = SB_DISCONTINUE_BIT + 1;

    typedef enum logic [2:0] {
        KIND_MEM_RD,
        KIND_MEM_WR,
        KIND_IO_RD,
        KIND_IO_WR,
        KIND_ATOMIC,
        KIND_MSG
    } crnc_kind_t;

    typedef enum {SRC_IDLE, SRC_LINK, SRC_QUEUE} crnc_src_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [KEEP_W-1:0] keep;
        logic last;
        logic sop;
        logic np;
        crnc_kind_t kind;
        logic [3:0] first_be;
        logic [3:0] last_be;
        logic [BE_W-1:0] byte_en;
        logic disc;
    } crnc_beat_t;
endpackage : crnc_pkg

// File: verif/crnc_user_sink.sv
// User-side sink model for the completer request stream.
// Assumes beats are taken on CLOCK_IN rising edges; ready moves on falling edges.
`timescale 1ns/1ps
module crnc_user_sink (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire logic valid_in,
    input wire logic last_in,
    input wire logic disc_in,
    output logic ready_out,
    output logic [7:0] kept_out,
    output logic [7:0] dropped_out
);
    logic phase = 1'b0;
    // Slow mode stalls every other cycle so the block must hold its beat.
    always @(negedge clk_in) begin
        phase <= ~phase;
        ready_out <= rst_n_in && (!slow_in || phase);
    end
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            kept_out <= 8'h00;
            dropped_out <= 8'h00;
        // Completions for taken requests leave on the completion port, outside this model.
        end else if (valid_in && ready_out && last_in) begin
            if (disc_in) begin
                dropped_out <= dropped_out + 8'h01;
            end else begin
                kept_out <= kept_out + 8'h01;
            end
        end
    end
endmodule : crnc_user_sink

// File: verif/completer_request_np_credit_test.sv
// Self-checking bench for the completer request framer and its credit counter.
// Assumes both sides of the framer run on the single 40 MHz clock.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t got %0h exp %0h", $time, (got), (exp)); end end
module completer_request_np_credit_test;
    import crnc_pkg::*;
    logic CLOCK_IN = 1'b0, RST_N_IN = 1'b0, lvalid = 1'b0, lready, llast = 1'b0, lsop = 1'b0;
    logic lnp = 1'b0, lecc = 1'b0, rvalid, rready, rlast, grant = 1'b0, fatal, slow = 1'b0;
    logic [127:0] ldata = '0, rdata;
    logic [3:0] lkeep = 4'h0, lfbe = 4'h0, llbe = 4'h0, rkeep;
    logic [15:0] lbe = 16'h0000;
    logic [SB_W-1:0] rsb;
    logic [5:0] level;
    logic [7:0] kept, dropped;
    crnc_kind_t lkind = KIND_MEM_RD, kind;
    logic np;
    int beats, num_errors = 0, samples_checked = 0, cycles = 0;
    logic [30:0] got_q[$];
    logic [127:0] dat_q[$];

    crnc_framer #(.Q_DEPTH(4)) dut (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
        .LINK_VALID_IN(lvalid), .LINK_READY_OUT(lready), .LINK_DATA_IN(ldata),
        .LINK_KEEP_IN(lkeep), .LINK_LAST_IN(llast), .LINK_SOP_IN(lsop), .LINK_NP_IN(lnp),
        .LINK_KIND_IN(lkind), .LINK_FIRST_BE_IN(lfbe), .LINK_LAST_BE_IN(llbe),
        .LINK_BYTE_EN_IN(lbe), .LINK_ECC_ERR_IN(lecc), .REQ_VALID_OUT(rvalid),
        .REQ_READY_IN(rready), .REQ_DATA_OUT(rdata), .REQ_BYTE_KEEP_OUT(rkeep),
        .REQ_LAST_BEAT_OUT(rlast), .REQ_SIDEBAND_BUS_OUT(rsb),
        .NONPOSTED_CREDIT_GRANT_IN(grant), .NONPOSTED_CREDIT_LEVEL_OUT(level),
        .FATAL_ERROR_OUT(fatal));
    crnc_user_sink user (.clk_in(CLOCK_IN), .rst_n_in(RST_N_IN), .slow_in(slow),
        .valid_in(rvalid), .last_in(rlast), .disc_in(rsb[SB_DISCONTINUE_BIT]),
        .ready_out(rready), .kept_out(kept), .dropped_out(dropped));

    initial forever #12.5 CLOCK_IN = ~CLOCK_IN;
    always @(posedge CLOCK_IN) begin
        if (RST_N_IN && rvalid && rready) begin
            got_q.push_back({rkeep, rlast, rsb});
            dat_q.push_back(rdata);
        end
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_sim;
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic send_pkt(input logic [31:0] tag, input crnc_kind_t k, input logic n_p,
            input int nb, input logic [3:0] fbe, input logic [3:0] lbe_in, input logic ecc);
        int n;
        for (int i = 0; i < nb; i++) begin
            @(negedge CLOCK_IN);
            lvalid = 1'b1;
            ldata = {4{tag + 32'(i)}};
            lsop = (i == 0);
            llast = (i == nb - 1);
            lkeep = llast ? 4'h1 : 4'hF;
            lnp = n_p;
            lkind = k;
            lfbe = fbe;
            llbe = lbe_in;
            lbe = tag[15:0];
            lecc = ecc && llast;
            n = 0;
            while (!lready && n < 200) begin
                @(negedge CLOCK_IN);
                n++;
            end
            @(posedge CLOCK_IN);
        end
        @(negedge CLOCK_IN);
        lvalid = 1'b0;
    endtask : send_pkt

    task automatic expect_pkt(input logic [31:0] tag, input crnc_kind_t k, input int nb,
            input logic [3:0] fbe, input logic [3:0] lbe_in, input logic disc);
        logic [3:0] f, l;
        logic lst;
        logic [30:0] g;
        logic [127:0] d;
        int n;
        for (int i = 0; i < nb; i++) begin
            n = 0;
            while (got_q.size() == 0 && n < 200) begin
                @(negedge CLOCK_IN);
                n++;
            end
            `CHK(got_q.size() > 0, 1'b1)
            if (got_q.size() > 0) begin
                lst = (i == nb - 1);
                f = (i == 0 && k != KIND_ATOMIC && k != KIND_MSG) ? fbe : BE_NONE;
                l = (i == 0 && k != KIND_ATOMIC && k != KIND_MSG) ? lbe_in : BE_NONE;
                g = got_q.pop_front();
                d = dat_q.pop_front();
                `CHK(d, {4{tag + 32'(i)}})
                `CHK(g, {lst ? 4'h1 : 4'hF, lst, disc && lst, i == 0, tag[15:0], l, f})
            end
        end
    endtask : expect_pkt

    initial begin
        repeat (6) @(negedge CLOCK_IN);
        `CHK(level, CREDIT_RESET)
        RST_N_IN = 1'b1;
        @(negedge CLOCK_IN);
        `CHK(lready, 1'b1)
        send_pkt(32'h0100, KIND_MEM_WR, 1'b0, 2, 4'hF, 4'hF, 1'b0);
        send_pkt(32'h0200, KIND_MEM_RD, 1'b1, 1, 4'h0, 4'h0, 1'b0);
        send_pkt(32'h0300, KIND_MSG, 1'b0, 1, 4'h3, 4'h3, 1'b0);
        repeat (10) @(negedge CLOCK_IN);
        expect_pkt(32'h0100, KIND_MEM_WR, 2, 4'hF, 4'hF, 1'b0);
        expect_pkt(32'h0300, KIND_MSG, 1, 4'h3, 4'h3, 1'b0);
        `CHK(got_q.size(), 0)
        grant = 1'b1;
        @(negedge CLOCK_IN);
        grant = 1'b0;
        expect_pkt(32'h0200, KIND_MEM_RD, 1, 4'h0, 4'h0, 1'b0);
        @(negedge CLOCK_IN);
        `CHK(level, CREDIT_RESET)
        $display("test stall ordering done");
        grant = 1'b1;
        repeat (40) @(negedge CLOCK_IN);
        `CHK(level, CREDIT_MAX)
        grant = 1'b0;
        slow = 1'b1;
        for (int k = 0; k < 6; k++) begin
            kind = crnc_kind_t'(k);
            np = kind inside {KIND_MEM_RD, KIND_IO_RD, KIND_IO_WR, KIND_ATOMIC};
            beats = (np && kind != KIND_ATOMIC) ? ((kind == KIND_IO_WR) ? 2 : 1) : 3;
            send_pkt(32'h1000 * (k + 1), kind, np, beats, 4'h5, 4'hA, 1'b0);
            expect_pkt(32'h1000 * (k + 1), kind, beats, 4'h5, 4'hA, 1'b0);
        end
        `CHK(level, CREDIT_MAX - 6'h04)
        $display("test kinds and credit done");
        slow = 1'b0;
        send_pkt(32'h5000, KIND_MEM_WR, 1'b0, 2, 4'hF, 4'hF, 1'b1);
        expect_pkt(32'h5000, KIND_MEM_WR, 2, 4'hF, 4'hF, 1'b1);
        @(negedge CLOCK_IN);
        `CHK(fatal, 1'b1)
        `CHK(dropped, 8'h01)
        `CHK(kept, 8'h09)
        RST_N_IN = 1'b0;
        repeat (2) @(negedge CLOCK_IN);
        `CHK(level, CREDIT_RESET)
        `CHK(fatal, 1'b0)
        RST_N_IN = 1'b1;
        $display("test abort and reset done");
        end_sim;
    end
endmodule : completer_request_np_credit_test
